// >>> verilog/hsc_cfg.svh
// Constants of the hot-swap sequence controller
// Assumes a 100 MHz ref_clk; included by bare name
`ifndef HSC_CFG_SVH
`define HSC_CFG_SVH

// ----------------------------------------------------------------
// Clock and filter timing
// ----------------------------------------------------------------
`define HSC_CLK_PERIOD_NS 10
`define HSC_EN_FILT_NS 3000
`define HSC_EN_FILT_CYC ((`HSC_EN_FILT_NS + `HSC_CLK_PERIOD_NS - 1) / `HSC_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Timing per microfarad of timer capacitance, in us per uF
// ----------------------------------------------------------------
`define HSC_T_COOL_US_PER_UF 550000
`define HSC_T_FAULT_US_PER_UF 21700
`define HSC_T_INIT_US_PER_UF 270000

// ----------------------------------------------------------------
// Comparator vector bit positions
// ----------------------------------------------------------------
`define HSC_CMP_UNDERVOLTAGE_LOCKOUT 0
`define HSC_CMP_EN 1
`define HSC_CMP_OCTIM 2
`define HSC_CMP_OCFAST 3
`define HSC_CMP_TUP 4
`define HSC_CMP_TLO 5
`define HSC_CMP_W 6

// ----------------------------------------------------------------
// FET drive select bit positions (one-hot)
// ----------------------------------------------------------------
`define HSC_GATE_SINK25M 0
`define HSC_GATE_SINK2M 1
`define HSC_GATE_PULL12U 2
`define HSC_GATE_FULL 3

// ----------------------------------------------------------------
// Timer current select bit positions (one-hot)
// ----------------------------------------------------------------
`define HSC_TMR_UP5U 0
`define HSC_TMR_UP60U 1
`define HSC_TMR_DN2U 2
`define HSC_TMR_DN100U 3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define HSC_GATE_RST 4'h1
`define HSC_TMR_RST 4'h8

`endif

// >>> verilog/hsc_pkg.sv
// Types of the hot-swap sequence controller
// Assumes hsc_cfg.svh for numeric constants
package hsc_pkg;

  typedef logic [3:0] hsc_sel_t;

  typedef enum logic [3:0] {
    ST_POR,
    ST_INIT_UP,
    ST_INIT_DOWN,
    ST_WAIT_EN,
    ST_RAMP,
    ST_LIMIT,
    ST_FULL,
    ST_LATCH,
    ST_COOL
  } hsc_state_t;

endpackage

// >>> verilog/hsc_cmp_if.sv
// Synchronised comparator levels between synchroniser and sequencer
// Assumes both ends run on ref_clk
`timescale 1ns/1ps

interface hsc_cmp_if;
  logic uvloOk;
  logic enable;
  logic ocTim;
  logic ocFast;
  logic timUpper;
  logic timLower;

  modport prod (
    output uvloOk,
    output enable,
    output ocTim,
    output ocFast,
    output timUpper,
    output timLower
  );

  modport cons (
    input uvloOk,
    input enable,
    input ocTim,
    input ocFast,
    input timUpper,
    input timLower
  );
endinterface

// >>> verilog/hsc_cmp_sync.sv
// Comparator synchroniser and enable glitch filter
// Assumes raw comparator levels asynchronous to ref_clk
`timescale 1ns/1ps
`include "hsc_cfg.svh"

module hsc_cmp_sync #(
  parameter int FILT_CYC = `HSC_EN_FILT_CYC
) (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    resetn,
  // Raw comparator levels
  input  wire logic [`HSC_CMP_W-1:0]   cmpRaw,
  // Synchronised levels
  hsc_cmp_if.prod                      cmp
);
  import hsc_pkg::*;

  localparam int CW = $clog2(FILT_CYC + 1);

  logic [`HSC_CMP_W-1:0] meta_q;
  logic [`HSC_CMP_W-1:0] meta_d;
  logic [`HSC_CMP_W-1:0] sync_q;
  logic [`HSC_CMP_W-1:0] sync_d;
  logic                  enFilt_q;
  logic                  enFilt_d;
  logic [CW-1:0]         cnt_q;
  logic [CW-1:0]         cnt_d;

  // ----------------------------------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------------------------------
  always_comb begin
    meta_d = cmpRaw;
    sync_d = meta_q;
  end

  // ----------------------------------------------------------------
  // Enable glitch filter
  // ----------------------------------------------------------------
  always_comb begin
    enFilt_d = enFilt_q;
    cnt_d    = '0;
    if (sync_q[`HSC_CMP_EN] != enFilt_q) begin
      if (cnt_q == CW'(FILT_CYC - 1)) begin
        enFilt_d = sync_q[`HSC_CMP_EN];
      end else begin
        cnt_d = cnt_q + CW'(1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      meta_q   <= '0;
      sync_q   <= '0;
      enFilt_q <= 1'h0;
      cnt_q    <= '0;
    end else begin
      meta_q   <= meta_d;
      sync_q   <= sync_d;
      enFilt_q <= enFilt_d;
      cnt_q    <= cnt_d;
    end
  end

  assign cmp.uvloOk   = sync_q[`HSC_CMP_UNDERVOLTAGE_LOCKOUT];
  assign cmp.enable   = enFilt_q;
  assign cmp.ocTim    = sync_q[`HSC_CMP_OCTIM];
  assign cmp.ocFast   = sync_q[`HSC_CMP_OCFAST];
  assign cmp.timUpper = sync_q[`HSC_CMP_TUP];
  assign cmp.timLower = sync_q[`HSC_CMP_TLO];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_sync_two_stage: assert property (@(posedge ref_clk) disable iff (!resetn)
    $past(resetn) && $past(resetn, 2) |-> sync_q == $past(cmpRaw, 2))
    else $error("comparator synchroniser is not two stages");

  chk_filter_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    $changed(enFilt_q) && $past(resetn) |-> $past(cnt_q) == CW'(FILT_CYC - 1))
    else $error("enable filter changed before its full hold time");
endmodule

// >>> verilog/hsc_sequencer.sv
// Hot-swap sequence controller: FET drive and timer source selection
// Assumes comparator levels from pins and one 100 MHz ref_clk
//
// Behaviour
// - FET drive low through init until enable
// - Leave power-on reset when supply ok
// - Reset selects 25 mA gate, 100 uA timer sink
// - Init phase one charges timer at 5 uA
// - Init phase two discharges at 100 uA
// - Start at once if enable high, else wait
// - Hot-swap start selects 12 uA gate pull-up
// - Overcurrent selects 60 uA timer pull-up
// - Current limiting enables error amplifier regulation
// - Overcurrent clear: timer sink, full gate enhancement
// - Timer at upper threshold: fault, 2 mA
// - Pull-down holds until a retry starts
// - Fast trip selects 2 mA pull-down immediately
// - Auto-retry cool-down uses 2 uA timer sink
// - Auto-retry restarts at lower timer threshold
// - Timing scales with timer capacitance
// - Enable low stops, grounds gate, resets timer
// - Enable passes a 3 us glitch filter
// - Latch-off waits for enable toggle
`timescale 1ns/1ps
`include "hsc_cfg.svh"

module hsc_sequencer #(
  parameter bit AUTO_RETRY = 1'h1,
  parameter int FILT_CYC   = `HSC_EN_FILT_CYC
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  // Comparator levels from the analog front end
  input  wire logic              supplyOk,
  input  wire logic              enablePin,
  input  wire logic              ocTimPin,
  input  wire logic              ocFastPin,
  input  wire logic              timUpperPin,
  input  wire logic              timLowerPin,
  // Current source selects
  output hsc_pkg::hsc_sel_t      gateSel,
  output hsc_pkg::hsc_sel_t      timerSel,
  output logic                   errAmpEn,
  // Status
  output logic                   faultActive
);
  import hsc_pkg::*;

  hsc_state_t state_q;
  hsc_state_t state_d;
  hsc_sel_t   gateSel_q;
  hsc_sel_t   gateSel_d;
  hsc_sel_t   timerSel_q;
  hsc_sel_t   timerSel_d;
  logic       errAmpEn_q;
  logic       errAmpEn_d;
  logic       fault_q;
  logic       fault_d;
  logic       swapOn;

  hsc_cmp_if cmp ();

  // ----------------------------------------------------------------
  // Comparator synchroniser
  // ----------------------------------------------------------------
  hsc_cmp_sync #(
    .FILT_CYC (FILT_CYC)
  ) uSync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .cmpRaw  ({timLowerPin, timUpperPin, ocFastPin, ocTimPin, enablePin, supplyOk}),
    .cmp     (cmp.prod)
  );

  // ----------------------------------------------------------------
  // Sequencing state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_POR: begin
        if (cmp.uvloOk) begin
          state_d = ST_INIT_UP;
        end
      end
      ST_INIT_UP: begin
        if (cmp.timUpper) begin
          state_d = ST_INIT_DOWN;
        end
      end
      ST_INIT_DOWN: begin
        if (cmp.timLower) begin
          state_d = cmp.enable ? ST_RAMP : ST_WAIT_EN;
        end
      end
      ST_WAIT_EN: begin
        if (cmp.enable) begin
          state_d = ST_RAMP;
        end
      end
      ST_RAMP: begin
        if (cmp.ocTim) begin
          state_d = ST_LIMIT;
        end
      end
      ST_LIMIT: begin
        if (!cmp.ocTim) begin
          state_d = ST_FULL;
        end else if (cmp.timUpper) begin
          state_d = AUTO_RETRY ? ST_COOL : ST_LATCH;
        end
      end
      ST_FULL: begin
        if (cmp.ocTim) begin
          state_d = ST_LIMIT;
        end
      end
      ST_LATCH: begin
        state_d = ST_LATCH;
      end
      ST_COOL: begin
        if (cmp.timLower) begin
          state_d = ST_RAMP;
        end
      end
      default: begin
        state_d = ST_POR;
      end
    endcase
    if (!cmp.enable && state_q inside {ST_RAMP, ST_LIMIT, ST_FULL, ST_LATCH, ST_COOL}) begin
      state_d = ST_WAIT_EN;
    end
    if (!cmp.uvloOk) begin
      state_d = ST_POR;
    end
  end

  assign swapOn = state_d inside {ST_RAMP, ST_LIMIT, ST_FULL};

  // ----------------------------------------------------------------
  // Source selection, decoded from the next state
  // ----------------------------------------------------------------
  always_comb begin
    gateSel_d  = '0;
    timerSel_d = '0;
    errAmpEn_d = 1'h0;
    fault_d    = 1'h0;
    // Durations follow the timer capacitance through these currents
    case (state_d)
      ST_POR: begin
        gateSel_d[`HSC_GATE_SINK25M] = 1'h1;
        timerSel_d[`HSC_TMR_DN100U]  = 1'h1;
      end
      ST_INIT_UP: begin
        gateSel_d[`HSC_GATE_SINK2M] = 1'h1;
        timerSel_d[`HSC_TMR_UP5U]   = 1'h1;
      end
      ST_INIT_DOWN, ST_WAIT_EN: begin
        gateSel_d[`HSC_GATE_SINK2M] = 1'h1;
        timerSel_d[`HSC_TMR_DN100U] = 1'h1;
      end
      ST_RAMP: begin
        gateSel_d[`HSC_GATE_PULL12U] = 1'h1;
        timerSel_d[`HSC_TMR_DN100U]  = 1'h1;
      end
      ST_LIMIT: begin
        gateSel_d[`HSC_GATE_PULL12U] = 1'h1;
        timerSel_d[`HSC_TMR_UP60U]   = 1'h1;
        errAmpEn_d                   = 1'h1;
      end
      ST_FULL: begin
        gateSel_d[`HSC_GATE_FULL]   = 1'h1;
        timerSel_d[`HSC_TMR_DN100U] = 1'h1;
      end
      ST_LATCH: begin
        gateSel_d[`HSC_GATE_SINK2M] = 1'h1;
        timerSel_d[`HSC_TMR_DN100U] = 1'h1;
        fault_d                     = 1'h1;
      end
      ST_COOL: begin
        gateSel_d[`HSC_GATE_SINK2M] = 1'h1;
        timerSel_d[`HSC_TMR_DN2U]   = 1'h1;
        fault_d                     = 1'h1;
      end
      default: begin
        gateSel_d[`HSC_GATE_SINK25M] = 1'h1;
        timerSel_d[`HSC_TMR_DN100U]  = 1'h1;
      end
    endcase
    if (swapOn && cmp.ocFast) begin
      gateSel_d = '0;
      gateSel_d[`HSC_GATE_SINK2M] = 1'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_q    <= ST_POR;
      gateSel_q  <= `HSC_GATE_RST;
      timerSel_q <= `HSC_TMR_RST;
      errAmpEn_q <= 1'h0;
      fault_q    <= 1'h0;
    end else begin
      state_q    <= state_d;
      gateSel_q  <= gateSel_d;
      timerSel_q <= timerSel_d;
      errAmpEn_q <= errAmpEn_d;
      fault_q    <= fault_d;
    end
  end

  assign gateSel     = gateSel_q;
  assign timerSel    = timerSel_q;
  assign errAmpEn    = errAmpEn_q;
  assign faultActive = fault_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_live;
    cmp.uvloOk && cmp.enable;
  endsequence

  sequence s_init_top;
    state_q == ST_INIT_UP && cmp.timUpper && cmp.uvloOk;
  endsequence

  sequence s_init_end_on;
    (state_q == ST_INIT_DOWN && cmp.timLower) and s_live;
  endsequence

  sequence s_fault_hit;
    (state_q == ST_LIMIT && cmp.ocTim && cmp.timUpper) and s_live;
  endsequence

  chk_por_drive: assert property (
    state_q == ST_POR |-> gateSel_q[`HSC_GATE_SINK25M] && timerSel_q[`HSC_TMR_DN100U])
    else $error("reset state lacks strong gate sink or timer sink");

  chk_por_exit: assert property (
    state_q == ST_POR && cmp.uvloOk |=> state_q == ST_INIT_UP)
    else $error("power-on reset not left with supply good");

  chk_gate_held: assert property (
    state_q inside {ST_INIT_UP, ST_INIT_DOWN, ST_WAIT_EN} |-> gateSel_q[`HSC_GATE_SINK2M])
    else $error("gate not held low before hot-swap start");

  chk_init_charge: assert property (
    state_q == ST_INIT_UP |-> timerSel_q[`HSC_TMR_UP5U])
    else $error("initial phase one not charging at 5 uA");

  chk_init_disch: assert property (
    s_init_top |=> state_q == ST_INIT_DOWN && timerSel_q[`HSC_TMR_DN100U])
    else $error("initial phase two not discharging at 100 uA");

  chk_start_now: assert property (
    s_init_end_on |=> state_q == ST_RAMP ##0 (gateSel_q[`HSC_GATE_PULL12U] || $past(cmp.ocFast)))
    else $error("hot-swap not started at end of initial cycle");

  chk_wait_start: assert property (
    state_q == ST_WAIT_EN ##1 s_live ##1 state_q == ST_RAMP && !$past(cmp.ocFast)
      |-> gateSel_q[`HSC_GATE_PULL12U])
    else $error("hot-swap start without 12 uA gate pull-up");

  chk_oc_timing: assert property (
    (state_q == ST_RAMP && cmp.ocTim) and s_live |=> timerSel_q[`HSC_TMR_UP60U] && state_q == ST_LIMIT)
    else $error("overcurrent not timed with 60 uA");

  chk_err_amp: assert property (
    errAmpEn_q == (state_q == ST_LIMIT))
    else $error("error amplifier mode outside current limiting");

  chk_oc_clear: assert property (
    (state_q == ST_LIMIT && !cmp.ocTim && !cmp.ocFast) and s_live
      |=> timerSel_q[`HSC_TMR_DN100U] && gateSel_q[`HSC_GATE_FULL])
    else $error("overcurrent clear did not restore timer sink and full drive");

  chk_fault: assert property (
    s_fault_hit |=> gateSel_q[`HSC_GATE_SINK2M] && faultActive ##0 (state_q inside {ST_COOL, ST_LATCH}))
    else $error("timer at upper threshold did not declare a fault");

  chk_fault_hold: assert property (
    (faultActive && !(state_q == ST_COOL && cmp.timLower)) and s_live |=> gateSel_q[`HSC_GATE_SINK2M])
    else $error("gate pull-down released before a retry");

  chk_fast_trip: assert property (
    (cmp.ocFast && state_q inside {ST_RAMP, ST_LIMIT, ST_FULL}) and s_live
      |=> gateSel_q[`HSC_GATE_SINK2M])
    else $error("fast trip did not pull the gate down");

  chk_cool_sink: assert property (
    state_q == ST_COOL |-> timerSel_q[`HSC_TMR_DN2U] && AUTO_RETRY)
    else $error("cool-down not using the 2 uA sink");

  chk_auto_retry: assert property (
    (state_q == ST_COOL && cmp.timLower) and s_live |=> state_q == ST_RAMP)
    else $error("cool-down end did not retry");

  chk_en_low: assert property (
    !cmp.enable && cmp.uvloOk && state_q inside {ST_RAMP, ST_LIMIT, ST_FULL, ST_LATCH, ST_COOL}
      |=> state_q == ST_WAIT_EN && timerSel_q[`HSC_TMR_DN100U] && gateSel_q[`HSC_GATE_SINK2M])
    else $error("enable low did not stop the hot-swap");

  chk_latch_off: assert property (
    (state_q == ST_LATCH) and s_live |=> state_q == ST_LATCH)
    else $error("latch-off left without an enable toggle");

  chk_one_hot: assert property (
    $onehot(gateSel_q) && $onehot(timerSel_q))
    else $error("more or fewer than one source selected");
endmodule

// >>> verif/hsc_afe_model.sv
// Behavioural model of the FET, sense resistor and timer capacitor
// Assumes one-hot selects from hsc_sequencer and a bench-commanded load
`timescale 1ns/1ps
`include "hsc_cfg.svh"

module hsc_afe_model #(
  parameter int UP_LVL = 13000,
  parameter int LO_LVL = 2000
) (
  // Clock
  input  wire logic              ref_clk,
  // Device selects
  input  wire hsc_pkg::hsc_sel_t gateSel,
  input  wire hsc_pkg::hsc_sel_t timerSel,
  // Load conditions from the bench
  input  wire logic              loadHeavy,
  input  wire logic              shortCkt,
  // Comparator levels to the device
  output logic                   ocTimPin,
  output logic                   ocFastPin,
  output logic                   timUpperPin,
  output logic                   timLowerPin
);
  import hsc_pkg::*;
  // ----------------------------------------------------------------
  // Timer capacitor, one unit per 1 uA per cycle
  // ----------------------------------------------------------------
  int capLvl = 0;
  int nxtLvl;
  always_comb begin
    nxtLvl = capLvl;
    if (timerSel[`HSC_TMR_UP5U]) nxtLvl = capLvl + 5;
    else if (timerSel[`HSC_TMR_UP60U]) nxtLvl = capLvl + 60;
    else if (timerSel[`HSC_TMR_DN2U]) nxtLvl = capLvl - 2;
    else if (timerSel[`HSC_TMR_DN100U]) nxtLvl = capLvl - 100;
    if (nxtLvl < 0) nxtLvl = 0;
    if (nxtLvl > 20000) nxtLvl = 20000;
  end
  always @(posedge ref_clk) begin
    capLvl <= nxtLvl;
  end
  // ----------------------------------------------------------------
  // Comparators; heavy load only draws current while the gate is up
  // ----------------------------------------------------------------
  assign ocTimPin    = loadHeavy & (gateSel[`HSC_GATE_PULL12U] | gateSel[`HSC_GATE_FULL]);
  assign ocFastPin   = shortCkt;
  assign timUpperPin = (capLvl >= UP_LVL);
  assign timLowerPin = (capLvl <= LO_LVL);
endmodule

// >>> verif/tb_hotswap_sequence_controller.sv
// Self-checking bench of hsc_sequencer, auto-retry and latch-off variants
// Assumes hsc_afe_model as the analog front end of each instance
`timescale 1ns/1ps

module tb_hotswap_sequence_controller;
  import hsc_pkg::*;
  localparam int FILT = 4;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic     ref_clk = 1'h0;
  logic     resetn = 1'h0;
  logic     supplyOk = 1'h0;
  logic     enablePin = 1'h0;
  logic     loadHeavy = 1'h0;
  logic     shortCkt = 1'h0;
  hsc_sel_t gateSel, timerSel, gateL, timerL;
  logic     errAmpEn, faultActive, errAmpL, faultL;
  logic     ocTim, ocFast, tUp, tLo, ocTimL, ocFastL, tUpL, tLoL;
  int       errTotal = 0;
  int       checksDone = 0;
  int       cycCount = 0;
  int       took;
  always #5 ref_clk = ~ref_clk;
  // ----------------------------------------------------------------
  // Devices and front ends
  // ----------------------------------------------------------------
  hsc_sequencer #(.AUTO_RETRY(1'h1), .FILT_CYC(FILT)) u_dut (.ref_clk(ref_clk), .resetn(resetn),
    .supplyOk(supplyOk), .enablePin(enablePin), .ocTimPin(ocTim), .ocFastPin(ocFast), .timUpperPin(tUp),
    .timLowerPin(tLo), .gateSel(gateSel), .timerSel(timerSel), .errAmpEn(errAmpEn), .faultActive(faultActive));
  hsc_afe_model u_afe (.ref_clk(ref_clk), .gateSel(gateSel), .timerSel(timerSel), .loadHeavy(loadHeavy),
    .shortCkt(shortCkt), .ocTimPin(ocTim), .ocFastPin(ocFast), .timUpperPin(tUp), .timLowerPin(tLo));
  hsc_sequencer #(.AUTO_RETRY(1'h0), .FILT_CYC(FILT)) u_dut_latch (.ref_clk(ref_clk), .resetn(resetn),
    .supplyOk(supplyOk), .enablePin(enablePin), .ocTimPin(ocTimL), .ocFastPin(ocFastL), .timUpperPin(tUpL),
    .timLowerPin(tLoL), .gateSel(gateL), .timerSel(timerL), .errAmpEn(errAmpL), .faultActive(faultL));
  hsc_afe_model u_afe_latch (.ref_clk(ref_clk), .gateSel(gateL), .timerSel(timerL), .loadHeavy(loadHeavy),
    .shortCkt(shortCkt), .ocTimPin(ocTimL), .ocFastPin(ocFastL), .timUpperPin(tUpL), .timLowerPin(tLoL));
  // ----------------------------------------------------------------
  // Shared checks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    checksDone++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [3:0] pick(input int sel);
    case (sel)
      0: return gateSel;
      1: return timerSel;
      2: return {3'h0, faultActive};
      3: return gateL;
      default: return {3'h0, faultL};
    endcase
  endfunction
  task automatic wait_sel(input int sel, input logic [3:0] val, input int maxCyc);
    string nm[5] = '{"gateSel", "timerSel", "faultActive", "gateLatch", "faultLatch"};
    took = 0;
    while (pick(sel) !== val && took < maxCyc) begin
      @(posedge ref_clk);
      #1;
      took++;
    end
    chk(nm[sel], val, pick(sel));
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  always @(negedge ref_clk) begin
    if (resetn === 1'h1 && !($onehot(gateSel) && $onehot(timerSel) && $onehot(gateL) && $onehot(timerL))) begin
      chk("oneHotSel", 4'h1, 4'h0);
    end
  end
  always @(posedge ref_clk) begin
    cycCount <= cycCount + 1;
    if (cycCount == 30000) begin
      errTotal++;
      end_of_test();
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_power_up();
    step(5);
    chk("gateSel", 4'h1, gateSel);
    chk("timerSel", 4'h8, timerSel);
    @(posedge ref_clk) resetn <= 1'h1;
    step(10);
    chk("gateSel", 4'h1, gateSel);
    @(posedge ref_clk) supplyOk <= 1'h1;
    wait_sel(1, 4'h1, 6);
    chk("gateSel", 4'h2, gateSel);
    wait_sel(1, 4'h8, 3000);
    chk("initUpLong", 4'h1, {3'h0, took >= 2590});
    step(300);
    chk("gateSel", 4'h2, gateSel);
    $display("test power_up done");
  endtask
  task automatic t_glitch_start();
    @(posedge ref_clk) enablePin <= 1'h1;
    step(2);
    @(posedge ref_clk) enablePin <= 1'h0;
    step(20);
    chk("gateSel", 4'h2, gateSel);
    @(posedge ref_clk) enablePin <= 1'h1;
    wait_sel(0, 4'h4, 12);
    chk("filterDelay", 4'h1, {3'h0, took >= FILT});
    $display("test glitch_start done");
  endtask
  task automatic t_limit_clear();
    @(posedge ref_clk) loadHeavy <= 1'h1;
    step(2);
    chk("timerSel", 4'h8, timerSel);
    step(1);
    chk("timerSel", 4'h2, timerSel);
    chk("errAmpEn", 4'h1, {3'h0, errAmpEn});
    step(50);
    @(posedge ref_clk) loadHeavy <= 1'h0;
    wait_sel(0, 4'h8, 6);
    chk("timerSel", 4'h8, timerSel);
    chk("errAmpEn", 4'h0, {3'h0, errAmpEn});
    @(posedge ref_clk) loadHeavy <= 1'h1;
    wait_sel(1, 4'h2, 6);
    @(posedge ref_clk) loadHeavy <= 1'h0;
    wait_sel(0, 4'h8, 6);
    $display("test limit_clear done");
  endtask
  task automatic t_fast_trip();
    @(posedge ref_clk) shortCkt <= 1'h1;
    step(3);
    chk("gateSel", 4'h2, gateSel);
    chk("faultActive", 4'h0, {3'h0, faultActive});
    @(posedge ref_clk) shortCkt <= 1'h0;
    wait_sel(0, 4'h8, 6);
    $display("test fast_trip done");
  endtask
  task automatic t_enable_off();
    @(posedge ref_clk) enablePin <= 1'h0;
    wait_sel(0, 4'h2, 12);
    chk("timerSel", 4'h8, timerSel);
    @(posedge ref_clk) enablePin <= 1'h1;
    wait_sel(0, 4'h4, 12);
    $display("test enable_off done");
  endtask
  task automatic t_fault_retry();
    @(posedge ref_clk) loadHeavy <= 1'h1;
    wait_sel(1, 4'h2, 6);
    wait_sel(2, 4'h1, 400);
    chk("faultTime", 4'h1, {3'h0, took >= 210 && took <= 230});
    chk("gateSel", 4'h2, gateSel);
    @(posedge ref_clk) loadHeavy <= 1'h0;
    step(4);
    chk("timerSel", 4'h4, timerSel);
    chk("faultLatch", 4'h1, {3'h0, faultL});
    chk("gateLatch", 4'h2, gateL);
    wait_sel(0, 4'h4, 6500);
    chk("coolTime", 4'h1, {3'h0, took >= 5400 && took <= 5800});
    chk("gateLatch", 4'h2, gateL);
    $display("test fault_retry done");
  endtask
  task automatic t_latch_toggle();
    @(posedge ref_clk) enablePin <= 1'h0;
    step(15);
    chk("gateLatch", 4'h2, gateL);
    @(posedge ref_clk) enablePin <= 1'h1;
    wait_sel(3, 4'h4, 12);
    chk("faultLatch", 4'h0, {3'h0, faultL});
    $display("test latch_toggle done");
  endtask
  task automatic t_undervoltage_lockout_restart();
    @(posedge ref_clk) supplyOk <= 1'h0;
    step(3);
    chk("gateSel", 4'h1, gateSel);
    chk("timerSel", 4'h8, timerSel);
    step(200);
    @(posedge ref_clk) supplyOk <= 1'h1;
    wait_sel(1, 4'h1, 6);
    wait_sel(0, 4'h4, 3500);
    chk("initTime", 4'h1, {3'h0, took >= 2600});
    $display("test undervoltage_lockout_restart done");
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    t_power_up();
    t_glitch_start();
    t_limit_clear();
    t_fast_trip();
    t_enable_off();
    t_fault_retry();
    t_latch_toggle();
    t_undervoltage_lockout_restart();
    end_of_test();
  end
endmodule
